// >>> common/eid_pkg.sv
// package for the external request front end: register map, fields, reset values, vectors
// assumes a single 125 MHz clock and a synchronous active-low reset
package eid_pkg;

  // ==========================================================================
  // register map (byte addresses, one word each)
  // ==========================================================================
  localparam logic [7:0] OFS_PEND   = 8'h00;
  localparam logic [7:0] OFS_ENABLE = 8'h04;
  localparam logic [7:0] OFS_SENSE  = 8'h08;
  localparam logic [7:0] OFS_PRIO_A = 8'h0c;
  localparam logic [7:0] OFS_SYSCTL = 8'h10;
  localparam logic [7:0] OFS_VECSTS = 8'h14;

  localparam logic [7:0] RST_ENABLE = 8'h00;
  localparam logic [7:0] RST_SENSE  = 8'h00;
  localparam logic [7:0] RST_PRIO_A = 8'h00;
  localparam logic [7:0] RST_SYSCTL = 8'h00;
  localparam logic [5:0] RST_PEND   = 6'h00;

  // system control fields
  localparam int SYS_NMI_EDGE_BIT = 0;  // 1 rising, 0 falling
  localparam int SYS_UE_BIT       = 1;  // user_bit_mode_enable

  // priority_level_reg_a fields
  localparam int PRA_IRQ0_BIT = 7;
  localparam int PRA_IRQ1_BIT = 6;
  localparam int PRA_IRQ23_BIT = 5;
  localparam int PRA_IRQ45_BIT = 4;
  localparam int PRA_SYS_BIT  = 3;   // watchdog, refresh, converter
  localparam int PRA_TMR0_BIT = 2;
  localparam int PRA_TMR1_BIT = 1;

  // ==========================================================================
  // sources, in ascending vector order
  // ==========================================================================
  localparam int NPIN  = 6;
  localparam int NINT  = 9;
  localparam int NSRC  = 16;
  localparam logic [5:0] VEC_NMI = 6'h07;
  localparam logic [5:0] SRC_VEC [NSRC] = '{6'h07, 6'h0c, 6'h0d, 6'h0e, 6'h0f, 6'h10, 6'h11,
                                           6'h14, 6'h15, 6'h17, 6'h18, 6'h19, 6'h1a,
                                           6'h1c, 6'h1d, 6'h1e};
  // priority bit per source, index into priority_level_reg_a (nmi unused)
  localparam int SRC_PRB [NSRC] = '{0, 7, 6, 5, 5, 4, 4, 3, 3, 3, 2, 2, 2, 1, 1, 1};
  // internal sources that may be routed to the dma controller
  localparam logic [8:0] DMA_CAPABLE = 9'h1fc;
  // pins that may leave software standby
  localparam logic [5:0] WAKE_PINS   = 6'h07;

  // ==========================================================================
  // carriers
  // ==========================================================================
  typedef struct packed {
    logic       valid;
    logic [5:0] number;
    logic [7:0] addr;
  } eid_vec_t;

  typedef struct packed {
    logic       write;
    logic       active;
    logic [7:0] addr;
  } eid_aphase_t;

endpackage : eid_pkg

// >>> dv/eid_cpu_model.sv
// cpu core model: takes the presented vector and acks it after a fixed delay
// assumes one clock, vec_i straight from the front end, ack_en_i from the bench
`timescale 1ns/1ps
`default_nettype none

module eid_cpu_model
#(
  parameter int DELAY = 3
)
(
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  input  wire logic              ack_en_i,
  input  wire eid_pkg::eid_vec_t vec_i,
  output logic                   ack_o,
  output logic [5:0]             ack_vec_o
);
  int cnt;

  // ==========================================================================
  // ack sequencing
  // ==========================================================================
  // one ack per presentation, then a gap so vec_i can drop before we look again
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      ack_vec_o <= 6'h00;
    if (!rstn_i || !ack_en_i || !vec_i.valid)
    begin
      ack_o <= 1'b0;
      cnt   <= 0;
    end
    else if (cnt == DELAY)
    begin
      ack_o     <= 1'b1;
      ack_vec_o <= vec_i.number;
      cnt       <= -2;  // vector moves two edges after the ack edge
    end
    else
    begin
      ack_o <= 1'b0;
      cnt   <= cnt + 1;
    end
  end
endmodule : eid_cpu_model

`default_nettype wire

// >>> dv/eid_irq_front_bench.sv
// bench for the external request front end: bus tasks, pin stimulus, vector checks
// assumes a single 125 MHz clock, one ahb-lite slave and the cpu model beside it
`timescale 1ns/1ps
`default_nettype none

module eid_irq_front_bench;
  logic              clk_i;
  logic              rstn_i;
  logic              hw_standby;
  logic              hsel;
  logic              hwrite;
  logic [1:0]        htrans;
  logic [2:0]        hsize;
  logic [31:0]       haddr;
  logic [31:0]       hwdata;
  logic              hreadyout;
  logic              hresp;
  logic [31:0]       hrdata;
  logic [5:0]        pin_n;
  logic              nmi_pin;
  logic [8:0]        int_req;
  logic [8:0]        dma_route;
  logic              cpu_i;
  logic              cpu_ui;
  logic              ack_en;
  logic              ack;
  logic [5:0]        ack_vec;
  eid_pkg::eid_vec_t vec;
  logic              wake;
  logic [31:0]       rd;
  int                failures;
  int                total_checks;

  // ==========================================================================
  // instances
  // ==========================================================================
  eid_irq_front i_eid_irq_front (
    .clk_i(clk_i), .rstn_i(rstn_i), .hw_standby_i(hw_standby), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
    .hwdata_i(hwdata), .hready_i(hreadyout), .hreadyout_o(hreadyout), .hresp_o(hresp),
    .hrdata_o(hrdata), .ext_req_pin_n_i(pin_n), .nmi_pin_i(nmi_pin), .int_req_i(int_req),
    .dma_route_i(dma_route), .cpu_i_mask_i(cpu_i), .cpu_ui_mask_i(cpu_ui), .ack_i(ack),
    .ack_vec_i(ack_vec), .vec_o(vec), .wake_o(wake));

  eid_cpu_model i_eid_cpu_model (
    .clk_i(clk_i), .rstn_i(rstn_i), .ack_en_i(ack_en), .vec_i(vec), .ack_o(ack),
    .ack_vec_o(ack_vec));

  // ==========================================================================
  // clock
  // ==========================================================================
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // ==========================================================================
  // shared tasks
  // ==========================================================================
  task automatic finish_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
  endtask : step

  // bounded: a slave that never answers ends the run as a mismatch
  task automatic wait_ready();
    int n;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      failures++;
      finish_test();
    end
  endtask : wait_ready

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rdv);
    @(posedge clk_i);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    hsize  <= 3'h2;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rdv = hrdata;
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d, rd);
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0, rd);
    check($sformatf("reg %h", a), rd, exp);
    check("hresp", {31'h0, hresp}, 32'h0);
  endtask : rchk

  // samples settled outputs, then realigns to a rising edge for the next drive
  task automatic vchk(input logic v, input logic [5:0] n, input logic w);
    #1;
    check("vec valid", {31'h0, vec.valid}, {31'h0, v});
    if (v)
      check("vec number", {18'h0, vec.number, vec.addr}, {18'h0, n, n, 2'b00});
    check("wake", {31'h0, wake}, {31'h0, w});
    @(posedge clk_i);
  endtask : vchk

  // ==========================================================================
  // scenarios
  // ==========================================================================
  task automatic s_regs_level();
    rchk(eid_pkg::OFS_ENABLE, 32'h0);
    rchk(eid_pkg::OFS_SENSE, 32'h0);
    wr(eid_pkg::OFS_ENABLE, 32'hc0);
    wr(eid_pkg::OFS_SENSE, 32'hc0);
    pin_n <= 6'h3e;
    step(4);
    rchk(eid_pkg::OFS_ENABLE, 32'hc0);
    rchk(eid_pkg::OFS_SENSE, 32'hc0);
    vchk(1'b0, 6'h00, 1'b0);
    rchk(8'h20, 32'h0);
    rchk(eid_pkg::OFS_PEND, 32'h01);
    wr(eid_pkg::OFS_ENABLE, 32'h01);
    step(3);
    vchk(1'b1, 6'd12, 1'b1);
    pin_n <= 6'h3f;
    // ones written to an armed flag keep it, and the write disarms it
    wr(eid_pkg::OFS_PEND, 32'h3f);
    wr(eid_pkg::OFS_PEND, 32'h0);
    rchk(eid_pkg::OFS_PEND, 32'h01);
    wr(eid_pkg::OFS_PEND, 32'h0);
    rchk(eid_pkg::OFS_PEND, 32'h0);
    vchk(1'b0, 6'h00, 1'b0);
  endtask : s_regs_level

  // held-low edge pin must not re-arm; then service clears per mode
  task automatic s_edge_service();
    wr(eid_pkg::OFS_SENSE, 32'h08);
    wr(eid_pkg::OFS_ENABLE, 32'h08);
    pin_n <= 6'h37;
    step(3);
    vchk(1'b1, 6'd15, 1'b0);
    rchk(eid_pkg::OFS_PEND, 32'h08);
    wr(eid_pkg::OFS_PEND, 32'h0);
    step(2);
    rchk(eid_pkg::OFS_PEND, 32'h0);
    pin_n  <= 6'h3f;
    ack_en <= 1'b1;
    wr(eid_pkg::OFS_ENABLE, 32'h09);
    pin_n <= 6'h37;
    step(20);
    rchk(eid_pkg::OFS_PEND, 32'h0);
    pin_n <= 6'h36;
    step(20);
    rchk(eid_pkg::OFS_PEND, 32'h01);
    pin_n <= 6'h3f;
    step(20);
    rchk(eid_pkg::OFS_PEND, 32'h0);
    ack_en <= 1'b0;
  endtask : s_edge_service

  task automatic s_prio();
    wr(eid_pkg::OFS_SENSE, 32'h0);
    wr(eid_pkg::OFS_ENABLE, 32'h21);
    pin_n <= 6'h1e;
    step(3);
    vchk(1'b1, 6'd12, 1'b1);
    wr(eid_pkg::OFS_PRIO_A, 32'h10);
    step(2);
    vchk(1'b1, 6'd17, 1'b1);
    rchk(eid_pkg::OFS_VECSTS, 32'h5144);
    cpu_i <= 1'b1;
    step(2);
    vchk(1'b1, 6'd17, 1'b1);
    cpu_ui <= 1'b1;
    step(2);
    vchk(1'b0, 6'h00, 1'b1);
    cpu_ui <= 1'b0;
    // user-bit mode on: the global mask alone blocks level one as well
    wr(eid_pkg::OFS_SYSCTL, 32'h02);
    step(2);
    vchk(1'b0, 6'h00, 1'b1);
    wr(eid_pkg::OFS_SYSCTL, 32'h0);
    wr(eid_pkg::OFS_PRIO_A, 32'h0);
    step(2);
    vchk(1'b0, 6'h00, 1'b1);
    cpu_i <= 1'b0;
    pin_n <= 6'h3f;
    rchk(eid_pkg::OFS_PEND, 32'h21);
    wr(eid_pkg::OFS_PEND, 32'h0);
  endtask : s_prio

  task automatic s_nmi();
    wr(eid_pkg::OFS_SYSCTL, 32'h0);
    cpu_i   <= 1'b1;
    nmi_pin <= 1'b0;
    step(3);
    vchk(1'b1, 6'd7, 1'b1);
    ack_en <= 1'b1;
    step(10);
    vchk(1'b0, 6'h00, 1'b0);
    ack_en <= 1'b0;
    wr(eid_pkg::OFS_SYSCTL, 32'h01);
    nmi_pin <= 1'b1;
    step(3);
    vchk(1'b1, 6'd7, 1'b1);
    ack_en <= 1'b1;
    step(10);
    ack_en  <= 1'b0;
    nmi_pin <= 1'b0;
    step(3);
    vchk(1'b0, 6'h00, 1'b0);
    cpu_i <= 1'b0;
  endtask : s_nmi

  task automatic s_internal();
    int_req <= 9'h001;
    step(3);
    vchk(1'b1, 6'd20, 1'b0);
    int_req   <= 9'h004;
    dma_route <= 9'h004;
    step(3);
    vchk(1'b0, 6'h00, 1'b0);
    dma_route <= 9'h000;
    step(3);
    vchk(1'b1, 6'd23, 1'b0);
    int_req <= 9'h040;
    step(3);
    vchk(1'b1, 6'd28, 1'b0);
    int_req <= 9'h000;
  endtask : s_internal

  task automatic s_standby();
    wr(eid_pkg::OFS_ENABLE, 32'hff);
    wr(eid_pkg::OFS_SENSE, 32'hff);
    hw_standby <= 1'b1;
    step(2);
    hw_standby <= 1'b0;
    step(1);
    rchk(eid_pkg::OFS_ENABLE, 32'h0);
    rchk(eid_pkg::OFS_SENSE, 32'h0);
  endtask : s_standby

  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial
  begin
    failures     = 0;
    total_checks = 0;
    rstn_i       = 1'b0;
    hw_standby   = 1'b0;
    hsel         = 1'b0;
    hwrite       = 1'b0;
    htrans       = 2'h0;
    hsize        = 3'h2;
    haddr        = 32'h0;
    hwdata       = 32'h0;
    pin_n        = 6'h3f;
    nmi_pin      = 1'b1;
    int_req      = 9'h000;
    dma_route    = 9'h000;
    cpu_i        = 1'b0;
    cpu_ui       = 1'b0;
    ack_en       = 1'b0;
    repeat (12) @(posedge clk_i);
    rstn_i <= 1'b1;
    step(2);
    s_regs_level();
    s_edge_service();
    s_prio();
    s_nmi();
    s_internal();
    s_standby();
    finish_test();
  end
endmodule : eid_irq_front_bench

`default_nettype wire

// >>> verilog/eid_irq_front.sv
// interrupt front end: pin sensing, pending flags, ranking, vector hand-off
// assumes an ahb-lite master as sole bus owner and a cpu core that acks vectors
//
// Design decisions made here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module eid_irq_front
(
  input  wire logic            clk_i,
  input  wire logic            rstn_i,
  input  wire logic            hw_standby_i,
  // ahb-lite slave
  input  wire logic            hsel_i,
  input  wire logic [31:0]     haddr_i,
  input  wire logic [1:0]      htrans_i,
  input  wire logic            hwrite_i,
  input  wire logic [2:0]      hsize_i,
  input  wire logic [31:0]     hwdata_i,
  input  wire logic            hready_i,
  output logic                 hreadyout_o,
  output logic                 hresp_o,
  output logic [31:0]          hrdata_o,
  // pins: request pins active low, nmi edge by polarity select
  input  wire logic [5:0]      ext_req_pin_n_i,
  input  wire logic            nmi_pin_i,
  // internal module requests and dma routing
  input  wire logic [8:0]      int_req_i,
  input  wire logic [8:0]      dma_route_i,
  // cpu side
  input  wire logic            cpu_i_mask_i,
  input  wire logic            cpu_ui_mask_i,
  input  wire logic            ack_i,
  input  wire logic [5:0]      ack_vec_i,
  output eid_pkg::eid_vec_t    vec_o,
  output logic                 wake_o
);

  // ==========================================================================
  // state
  // ==========================================================================
  logic [7:0]            enable_reg;
  logic [7:0]            sense_reg;
  logic [7:0]            prio_a;
  logic [7:0]            sysctl;
  logic [5:0]            pend;
  logic [5:0]            arm;
  logic [5:0]            pin_q;
  logic                  nmi_q;
  logic                  nmi_pend;
  eid_pkg::eid_aphase_t  aph;

  logic [5:0]            lvl_hit;
  logic [5:0]            edge_hit;
  logic [5:0]            set_hit;
  logic [5:0]            svc_clr;
  logic [5:0]            sw_clr;
  logic                  nmi_edge;
  logic                  wr_go;
  logic                  rd_go;

  // ==========================================================================
  // pin sensing
  // ==========================================================================
  // raw pin value is used, so the pin direction setting never hides a request
  assign lvl_hit  = ~sense_reg[5:0] & ~ext_req_pin_n_i;
  assign edge_hit = sense_reg[5:0] & pin_q & ~ext_req_pin_n_i;
  assign set_hit  = lvl_hit | edge_hit;

  // previous pin samples for edge detection
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i || hw_standby_i)
    begin
      pin_q <= 6'h3f;
      nmi_q <= 1'b0;
    end
    else
    begin
      pin_q <= ext_req_pin_n_i;
      nmi_q <= nmi_pin_i;
    end
  end

  // nonmaskable edge by polarity select
  assign nmi_edge = sysctl[eid_pkg::SYS_NMI_EDGE_BIT] ? (nmi_pin_i & ~nmi_q)
                                                      : (~nmi_pin_i & nmi_q);

  // service clears: edge mode always, level mode only once the pin is high
  genvar gi;
  generate
    for (gi = 0; gi < eid_pkg::NPIN; gi++)
    begin : g_svc
      assign svc_clr[gi] = ack_i && (ack_vec_i == eid_pkg::SRC_VEC[gi+1]) &&
                           (sense_reg[gi] || ext_req_pin_n_i[gi]);
    end
  endgenerate

  // ==========================================================================
  // bus slave, zero wait states
  // ==========================================================================
  assign rd_go = hsel_i && hready_i && htrans_i[1] && !hwrite_i;
  assign wr_go = aph.active && aph.write;
  // a zero clears only where the same bit was seen set by an earlier read
  assign sw_clr = (wr_go && aph.addr == eid_pkg::OFS_PEND) ? (arm & ~hwdata_i[5:0])
                                                           : 6'h00;

  // address phase capture
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      aph <= '0;
    else if (hready_i)
    begin
      aph.active <= hsel_i && htrans_i[1] && (hsize_i == 3'h2);
      aph.write  <= hwrite_i;
      aph.addr   <= haddr_i[7:0];
    end
  end

  // response lines: ready once out of reset, always okay
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      hreadyout_o <= 1'b0;
      hresp_o     <= 1'b0;
    end
    else
    begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end
  end

  // read data registered at the address phase; unmapped words read zero
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      hrdata_o <= 32'h0000_0000;
    else if (rd_go)
    begin
      unique case (haddr_i[7:0])
        eid_pkg::OFS_PEND:   hrdata_o <= {26'h0, pend};
        eid_pkg::OFS_ENABLE: hrdata_o <= {24'h0, enable_reg};
        eid_pkg::OFS_SENSE:  hrdata_o <= {24'h0, sense_reg};
        eid_pkg::OFS_PRIO_A: hrdata_o <= {24'h0, prio_a};
        eid_pkg::OFS_SYSCTL: hrdata_o <= {24'h0, sysctl};
        eid_pkg::OFS_VECSTS: hrdata_o <= {17'h0, vec_o};
        default:             hrdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // control registers
  // ==========================================================================
  // full 8 bits stored; bits 7:6 do nothing downstream except in prio_a
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i || hw_standby_i)
    begin
      enable_reg <= eid_pkg::RST_ENABLE;
      sense_reg  <= eid_pkg::RST_SENSE;
      prio_a     <= eid_pkg::RST_PRIO_A;
      sysctl     <= eid_pkg::RST_SYSCTL;
    end
    else if (wr_go)
    begin
      if (aph.addr == eid_pkg::OFS_ENABLE) enable_reg <= hwdata_i[7:0];
      if (aph.addr == eid_pkg::OFS_SENSE)  sense_reg  <= hwdata_i[7:0];
      if (aph.addr == eid_pkg::OFS_PRIO_A) prio_a     <= hwdata_i[7:0];
      if (aph.addr == eid_pkg::OFS_SYSCTL) sysctl     <= hwdata_i[7:0];
    end
  end

  // ==========================================================================
  // pending flags
  // ==========================================================================
  // set wins over any clear in the same cycle so no request is dropped
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i || hw_standby_i)
      pend <= eid_pkg::RST_PEND;
    else
      pend <= (pend & ~(sw_clr | svc_clr)) | set_hit;
  end

  // read of the flag register arms the bits read as one; any write to it disarms
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i || hw_standby_i)
      arm <= 6'h00;
    else if (rd_go && haddr_i[7:0] == eid_pkg::OFS_PEND)
      arm <= pend;
    else if (wr_go && aph.addr == eid_pkg::OFS_PEND)
      arm <= 6'h00;
  end

  // nonmaskable latch, cleared by its own service
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i || hw_standby_i)
      nmi_pend <= 1'b0;
    else if (nmi_edge)
      nmi_pend <= 1'b1;
    else if (ack_i && ack_vec_i == eid_pkg::VEC_NMI)
      nmi_pend <= 1'b0;
  end

  // ==========================================================================
  // arbitration
  // ==========================================================================
  logic [eid_pkg::NSRC-1:0] src_req;
  logic [eid_pkg::NSRC-1:0] src_hi;
  logic                     allow_lo;
  logic                     allow_hi;
  logic                     win_valid;
  logic [5:0]               win_vec;

  assign src_req[0] = nmi_pend;
  assign src_req[eid_pkg::NPIN:1] = pend & enable_reg[5:0];
  assign src_req[eid_pkg::NSRC-1:eid_pkg::NPIN+1] =
           int_req_i & ~(dma_route_i & eid_pkg::DMA_CAPABLE);

  // shared bits for pins 2/3 and 4/5 come from the source table
  generate
    for (gi = 0; gi < eid_pkg::NSRC; gi++)
    begin : g_lvl
      if (gi == 0)
      begin : g_nmi
        assign src_hi[gi] = 1'b1;
      end
      else
      begin : g_oth
        assign src_hi[gi] = prio_a[eid_pkg::SRC_PRB[gi]];
      end
    end
  endgenerate

  // masking: level one also passes when user mode off and user mask clear
  assign allow_lo = !cpu_i_mask_i;
  assign allow_hi = !cpu_i_mask_i ||
                    (!sysctl[eid_pkg::SYS_UE_BIT] && !cpu_ui_mask_i);

  // lowest index wins inside a level because the table is in vector order
  always_comb
  begin
    win_valid = 1'b0;
    win_vec   = 6'h00;
    if (nmi_pend)
    begin
      win_valid = 1'b1;
      win_vec   = eid_pkg::VEC_NMI;
    end
    else
    begin
      for (int k = eid_pkg::NSRC - 1; k >= 1; k--)
      begin
        if (src_req[k] && !src_hi[k] && allow_lo)
        begin
          win_valid = 1'b1;
          win_vec   = eid_pkg::SRC_VEC[k];
        end
      end
      for (int k = eid_pkg::NSRC - 1; k >= 1; k--)
      begin
        if (src_req[k] && src_hi[k] && allow_hi)
        begin
          win_valid = 1'b1;
          win_vec   = eid_pkg::SRC_VEC[k];
        end
      end
    end
  end

  // registered hand-off to the core
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i || hw_standby_i)
      vec_o <= '0;
    else
    begin
      vec_o.valid  <= win_valid;
      vec_o.number <= win_vec;
      vec_o.addr   <= {win_vec, 2'b00};
    end
  end

  // standby exit request; pins 3 to 5 cannot wake
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i || hw_standby_i)
      wake_o <= 1'b0;
    else
      wake_o <= nmi_pend || |(pend & enable_reg[5:0] & eid_pkg::WAKE_PINS);
  end

  // ==========================================================================
  // checks
  // ==========================================================================
  logic rd_pend_q;
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      rd_pend_q <= 1'b0;
    else
      rd_pend_q <= rd_go && haddr_i[7:0] == eid_pkg::OFS_PEND;
  end

  sequence s_masked_all;
    cpu_i_mask_i && sysctl[eid_pkg::SYS_UE_BIT];
  endsequence

  sequence s_only_nmi_out;
    !vec_o.valid || vec_o.number == eid_pkg::VEC_NMI;
  endsequence

  AST_LEVEL_SET: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (lvl_hit != 6'h00 && !hw_standby_i) |=> ((pend & $past(lvl_hit)) == $past(lvl_hit)))
    else $error("level request did not set its flag");

  AST_EDGE_SET: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (edge_hit != 6'h00 && !hw_standby_i) |=> ((pend & $past(edge_hit)) == $past(edge_hit)))
    else $error("falling edge did not set its flag");

  AST_SW_CLEAR: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (sw_clr != 6'h00 && set_hit == 6'h00 && !ack_i) |=> ((pend & $past(sw_clr)) == 6'h00))
    else $error("armed zero write did not clear the flag");

  AST_NO_ARM_KEEP: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (wr_go && aph.addr == eid_pkg::OFS_PEND && arm == 6'h00 && !ack_i && !hw_standby_i)
      |=> ((pend & $past(pend)) == $past(pend)))
    else $error("unarmed write changed a flag");

  AST_RSV_ZERO: assert property (@(posedge clk_i) disable iff (!rstn_i)
    rd_pend_q |-> hrdata_o[7:6] == 2'b00)
    else $error("reserved flag bits read nonzero");

  AST_STBY_CLR: assert property (@(posedge clk_i) disable iff (!rstn_i)
    hw_standby_i |=> (enable_reg == 8'h00 && sense_reg == 8'h00 && !vec_o.valid))
    else $error("standby did not clear enable and sense");

  AST_NMI_FIRST: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (nmi_pend && !hw_standby_i) |=> (vec_o.valid && vec_o.number == 6'h07))
    else $error("nonmaskable request not presented on vector seven");

  AST_MASK_ALL: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_masked_all |=> s_only_nmi_out)
    else $error("masked request reached the core");

  AST_ADDR_X4: assert property (@(posedge clk_i) disable iff (!rstn_i)
    vec_o.valid |-> vec_o.addr == {vec_o.number, 2'b00})
    else $error("vector address not four times the number");

  AST_NO_ENABLE: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (src_req == '0) |=> !vec_o.valid)
    else $error("vector raised with no enabled source");

endmodule : eid_irq_front

`default_nettype wire
